// >>> hdl/pgp_port1.sv
// port-one gpio with pin function selection and a classic wishbone slave
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pgp_port1
	import pgp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_o,
	output logic [7:0] pullup_o,
	output pgp_alt_t alt_o
);
	function automatic logic [7:0] pgp_merge(input logic [7:0] old,
		input logic [7:0] wdat, input logic [7:0] wmask);
		pgp_merge = (old & ~wmask) | (wdat & wmask);
	endfunction

	pgp_req_t req;
	logic [7:0] pin_meta_q, pin_sync_q;
	logic [7:0] func_q, dir_q, latch_q, pull_q;
	logic [7:0] func_d, dir_d, latch_d, pull_d;
	logic ack_q, err_q;
	logic [31:0] rdat_q;
	pgp_alt_t alt_q;
	logic [7:0] oe_q, out_q, pu_q;

	assign req = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};

	wire access = cyc_i && stb_i && !ack_q && !err_q;
	wire hit_func = req.adr == PGP_OFS_FUNC;
	wire hit_dir = req.adr == PGP_OFS_DIR;
	wire hit_latch = req.adr == PGP_OFS_LATCH;
	wire hit_pull = req.adr == PGP_OFS_PULLUP;
	wire mapped = hit_func | hit_dir | hit_latch | hit_pull;
	wire wr_en = access && mapped && req.we && req.sel[0];

	// one register carries port-one and port-two selections
	wire sel_seven = func_q[PGP_BIT_SEL_SEVEN];
	wire sel_four = func_q[PGP_BIT_SEL_FOUR];

	// general-io mask: alternate-input pins leave gpio control
	wire [7:0] gpio_mask = ~({sel_seven, 7'h00} | {3'h0, sel_four, 4'h0});

	// reserved bits never stored, forced on read
	assign func_d = (wr_en && hit_func) ?
		pgp_merge(func_q, req.dat[7:0], PGP_FUNC_WMASK) : func_q;
	// direction write-only, bit 3 never stored
	assign dir_d = (wr_en && hit_dir) ?
		pgp_merge(dir_q, req.dat[7:0], PGP_PORT_WMASK) : dir_q;
	assign latch_d = (wr_en && hit_latch) ?
		pgp_merge(latch_q, req.dat[7:0], PGP_PORT_WMASK) : latch_q;
	assign pull_d = (wr_en && hit_pull) ?
		pgp_merge(pull_q, req.dat[7:0], PGP_PORT_WMASK) : pull_q;

	wire [7:0] latch_rd = ((latch_q & dir_q) | (pin_sync_q & ~dir_q)
		& PGP_PORT_WMASK) | PGP_PORT_ONES;
	wire [7:0] func_rd = (func_q & PGP_FUNC_WMASK) | PGP_FUNC_ONES;
	wire [7:0] pull_rd = (pull_q & PGP_PORT_WMASK) | PGP_PORT_ONES;
	// direction is write-only and reads as zero
	wire [7:0] rd_byte = hit_func ? func_rd :
		hit_latch ? latch_rd :
		hit_pull ? pull_rd : 8'h00;

	// direction applies only to gpio-selected pins
	wire [7:0] oe_d = dir_q & gpio_mask & PGP_PORT_WMASK;
	wire [7:0] out_d = latch_q & oe_d;
	// pullup only while direction bit is zero
	wire [7:0] pu_d = pull_q & ~dir_q & gpio_mask & PGP_PORT_WMASK;

	// forward synchronised level on alternate pins
	pgp_alt_t alt_d;
	wire int_three_lvl = sel_seven ? pin_sync_q[7] : 1'b1;
	wire int_zero_lvl = sel_four ? pin_sync_q[4] : 1'b1;
	// transmit-select passed to the port-two pin logic
	wire txd_lvl = func_q[PGP_BIT_SEL_TXD];
	// one driver for the whole struct keeps the variable single-sourced
	assign alt_d = '{ext_int_three: int_three_lvl, timer_trig: int_three_lvl,
		ext_int_zero: int_zero_lvl, txd_sel: txd_lvl};

	always_ff @(posedge clk_i) begin
		pin_meta_q <= pin_i;
		pin_sync_q <= pin_meta_q;
	end

	// all control bits clear so every pin is input
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			func_q <= PGP_RST_VAL;
			dir_q <= PGP_RST_VAL;
			latch_q <= PGP_RST_VAL;
			pull_q <= PGP_RST_VAL;
		end else begin
			func_q <= func_d;
			dir_q <= dir_d;
			latch_q <= latch_d;
			pull_q <= pull_d;
		end
	end

	// one-cycle answer; unmapped address answered with err
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ack_q <= access && mapped;
			err_q <= access && !mapped;
			rdat_q <= (access && mapped && !req.we) ?
				{24'h000000, rd_byte} : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oe_q <= 8'h00;
			out_q <= 8'h00;
			pu_q <= 8'h00;
			alt_q <= 4'hE;
		end else begin
			oe_q <= oe_d;
			out_q <= out_d;
			pu_q <= pu_d;
			alt_q <= alt_d;
		end
	end

	assign dat_o = rdat_q;
	assign ack_o = ack_q;
	assign err_o = err_q;
	assign pin_o = out_q;
	assign pin_oe_o = oe_q;
	assign pullup_o = pu_q;
	assign alt_o = alt_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	pin7_mux_a: assert property (func_q[7] |=> !pin_oe_o[7])
		else $error("pin seven driven while alternate selected");
	pin4_mux_a: assert property (func_q[4] |=> !pin_oe_o[4])
		else $error("pin four driven while alternate selected");
	txd_sel_a: assert property (
		alt_o.txd_sel == $past(func_q[1]))
		else $error("transmit select not forwarded");
	func_rsv_a: assert property (func_rd[6:5] == 2'b00 && !func_rd[0])
		else $error("reserved select bits not zero");
	func_one_a: assert property (func_rd[3])
		else $error("select bit 3 not one");
	dir_out_a: assert property (dir_q[2] |=>
		pin_oe_o[2])
		else $error("direction one did not enable output");
	dir_rsv_a: assert property (!dir_q[3])
		else $error("direction bit 3 stored");
	latch_drv_a: assert property (dir_q[0] |=>
		pin_o[0] == $past(latch_q[0]))
		else $error("latch not on output pin");
	rd_latch_a: assert property (access && hit_latch && !req.we
		&& dir_q[1] |=> dat_o[1] == $past(latch_q[1]))
		else $error("output pin read not latch");
	rd_pin_a: assert property (access && hit_latch && !req.we
		&& !dir_q[1] |=> dat_o[1] == $past(pin_sync_q[1]))
		else $error("input pin read not pin level");
	rsv_one_a: assert property (latch_rd[3] && pull_rd[3])
		else $error("latch or pullup bit 3 not one");
	pull_gate_a: assert property (dir_q[5] |=> !pullup_o[5])
		else $error("pullup on an output pin");
	alt_fwd_a: assert property (sel_four |=>
		alt_o.ext_int_zero == $past(pin_sync_q[4]))
		else $error("interrupt zero level not forwarded");
	rsv_wr_a: assert property (!pull_q[3] && !latch_q[3])
		else $error("reserved bit stored");
	p7_dir_a: assert property (sel_seven |-> !oe_d[7])
		else $error("direction honoured on alternate pin");

	// bus answer: one-cycle pulses, never both at once
	ack_once_a: assert property (
		ack_o |=> !ack_o)
		else $error("ack held past one cycle");

	err_once_a: assert property (
		err_o |=> !err_o)
		else $error("err held past one cycle");

	ack_err_a: assert property (
		!(ack_o && err_o))
		else $error("ack and err together");

	ack_resp_a: assert property (
		access && mapped |=> ack_o)
		else $error("mapped access not acknowledged");

	err_resp_a: assert property (
		access && !mapped |=> err_o)
		else $error("unmapped access not refused");

	rdat_idle_a: assert property (
		!ack_o |-> dat_o == 32'h00000000)
		else $error("read data outside ack");

	dat_high_a: assert property (
		dat_o[31:8] == 24'h000000)
		else $error("read data upper bytes not zero");

	oe_rsv_a: assert property (
		!pin_oe_o[3])
		else $error("reserved pin enabled");

	out_rsv_a: assert property (
		!pin_o[3])
		else $error("reserved pin driven high");

	pu_rsv_a: assert property (
		!pullup_o[3])
		else $error("reserved pullup on");

	out_gate_a: assert property (
		(pin_o & ~pin_oe_o) == 8'h00)
		else $error("output level on undriven pin");

	pu_oe_a: assert property (
		(pullup_o & pin_oe_o) == 8'h00)
		else $error("pullup on a driven pin");

	func_wr_a: assert property (
		wr_en && hit_func |=> func_q == ($past(req.dat[7:0]) & PGP_FUNC_WMASK))
		else $error("select write not stored");

	dir_wr_a: assert property (
		wr_en && hit_dir |=> dir_q == ($past(req.dat[7:0]) & PGP_PORT_WMASK))
		else $error("direction write not stored");

	latch_wr_a: assert property (
		wr_en && hit_latch |=> latch_q == ($past(req.dat[7:0]) & PGP_PORT_WMASK))
		else $error("latch write not stored");

	pull_wr_a: assert property (
		wr_en && hit_pull |=> pull_q == ($past(req.dat[7:0]) & PGP_PORT_WMASK))
		else $error("pullup write not stored");

	int3_fwd_a: assert property (
		sel_seven |=> alt_o.ext_int_three == $past(pin_sync_q[7]))
		else $error("interrupt three level not forwarded");

	trig_fwd_a: assert property (
		sel_seven |=> alt_o.timer_trig == $past(pin_sync_q[7]))
		else $error("trigger level not forwarded");

	int0_idle_a: assert property (
		!sel_four |=> alt_o.ext_int_zero)
		else $error("interrupt zero not idle");

	wr_ignore_a: assert property (
		access && !mapped |=> $stable(func_q) && $stable(dir_q)
		&& $stable(latch_q) && $stable(pull_q))
		else $error("refused access changed a register");

	rd_pull_a: assert property (
		access && hit_pull && !req.we |=>
		dat_o[7:0] == ($past(pull_q) | PGP_PORT_ONES))
		else $error("pullup readback wrong");

	rd_dir_a: assert property (
		access && hit_dir && !req.we |=> dat_o == 32'h00000000)
		else $error("direction read not zero");

	rd_func_a: assert property (
		access && hit_func && !req.we |=>
		dat_o[7:0] == ($past(func_q) | PGP_FUNC_ONES))
		else $error("select readback wrong");

	p7_drive_a: assert property (
		!sel_seven && dir_q[7] |=> pin_oe_o[7])
		else $error("pin seven output not enabled");

	p4_drive_a: assert property (
		!sel_four && dir_q[4] |=> pin_oe_o[4])
		else $error("pin four output not enabled");

	pu_on_a: assert property (
		pull_q[6] && !dir_q[6] |=> pullup_o[6])
		else $error("pullup not on for input pin");

	p4_dir_a: assert property (
		sel_four |-> !oe_d[4])
		else $error("direction honoured on pin four");

	pu_alt_a: assert property (
		sel_seven |-> !pu_d[7])
		else $error("pullup on alternate pin seven");
endmodule
`default_nettype wire

// >>> hdl/pgp_pkg.sv
// package for the port-one gpio block with pin multiplexing
package pgp_pkg;
	localparam logic [3:0] PGP_OFS_FUNC = 4'h0;
	localparam logic [3:0] PGP_OFS_DIR = 4'h4;
	localparam logic [3:0] PGP_OFS_LATCH = 4'h8;
	localparam logic [3:0] PGP_OFS_PULLUP = 4'hC;
	localparam int PGP_BIT_SEL_SEVEN = 7;
	localparam int PGP_BIT_SEL_FOUR = 4;
	localparam int PGP_BIT_SEL_TXD = 1;
	// function-select: writable bits, bits forced to one
	localparam logic [7:0] PGP_FUNC_WMASK = 8'h96;
	localparam logic [7:0] PGP_FUNC_ONES = 8'h08;
	// port-one registers: bit 3 has no pin
	localparam logic [7:0] PGP_PORT_WMASK = 8'hF7;
	localparam logic [7:0] PGP_PORT_ONES = 8'h08;
	localparam logic [7:0] PGP_RST_VAL = 8'h00;
	typedef struct packed {
		logic [3:0] adr;
		logic we;
		logic [3:0] sel;
		logic [31:0] dat;
	} pgp_req_t;
	typedef struct packed {
		logic ext_int_three;
		logic timer_trig;
		logic ext_int_zero;
		logic txd_sel;
	} pgp_alt_t;
endpackage

// >>> verif/pgp_board.sv
// board-side model of the signals on the port pins
`timescale 1ns/1ps
`default_nettype none
module pgp_board (
	input wire logic clk_i,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_o,
	input wire logic [7:0] pullup_o,
	input wire logic [7:0] ext_val_i,
	input wire logic [7:0] ext_en_i,
	output logic [7:0] pin_i
);
	logic [7:0] flt_q = 8'h55;
	// an open line wanders, so a stale level is never trusted
	always_ff @(posedge clk_i) flt_q <= ~flt_q;
	assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i)
		| (~pin_oe_o & ~ext_en_i & (pullup_o | flt_q));
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the port-one gpio block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pgp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic ack_o, err_o, e;
	logic [7:0] pin_i, pin_o, pin_oe_o, pullup_o, rd;
	logic [7:0] ext_val = 8'h34, ext_en = 8'hFF;
	pgp_alt_t alt_o;
	int err_count = 0, n_checks = 0;
	always #5 clk_i = ~clk_i;
	pgp_port1 u_pgp_port1 (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .err_o, .pin_i, .pin_o, .pin_oe_o,
		.pullup_o, .alt_o);
	pgp_board u_pgp_board (.clk_i, .pin_o, .pin_oe_o, .pullup_o,
		.ext_val_i(ext_val), .ext_en_i(ext_en), .pin_i);
	task automatic finish_test();
		if (err_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
		int n;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
		rd = dat_o[7:0];
		e = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 20) begin
			err_count++;
			finish_test();
		end
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(pin_oe_o, 8'h00);
		chk({4'h0, alt_o}, 8'h0E);
		wb(PGP_OFS_FUNC, 1'b0, 8'h00);
		chk(rd, 8'h08);
		wb(PGP_OFS_LATCH, 1'b0, 8'h00);
		chk(rd, 8'h3C);
		wb(PGP_OFS_PULLUP, 1'b0, 8'h00);
		chk(rd, 8'h08);
		wb(PGP_OFS_DIR, 1'b1, 8'h0F);
		wb(PGP_OFS_DIR, 1'b0, 8'h00);
		chk(rd, 8'h00);
		wb(PGP_OFS_LATCH, 1'b1, 8'hA5);
		wb(PGP_OFS_LATCH, 1'b0, 8'h00);
		chk(rd, 8'h3D);
		chk(pin_oe_o, 8'h07);
		chk(pin_o, 8'h05);
		wb(PGP_OFS_PULLUP, 1'b1, 8'hFF);
		wb(PGP_OFS_PULLUP, 1'b0, 8'h00);
		chk(rd, 8'hFF);
		chk(pullup_o, 8'hF0);
		ext_en <= 8'h0F;
		repeat (4) @(posedge clk_i);
		wb(PGP_OFS_LATCH, 1'b0, 8'h00);
		chk(rd, 8'hFD);
		ext_en <= 8'hFF;
		// bit 2 stays clear: the value written leaves it zero
		wb(PGP_OFS_FUNC, 1'b1, 8'hFB);
		wb(PGP_OFS_DIR, 1'b1, 8'hFF);
		wb(PGP_OFS_FUNC, 1'b0, 8'h00);
		chk(rd, 8'h9A);
		chk(pin_oe_o, 8'h67);
		chk(pullup_o, 8'h00);
		ext_val <= 8'h80;
		repeat (6) @(posedge clk_i);
		chk({4'h0, alt_o}, 8'h0D);
		ext_val <= 8'h10;
		repeat (6) @(posedge clk_i);
		chk({4'h0, alt_o}, 8'h03);
		wb(PGP_OFS_FUNC, 1'b1, 8'h00);
		repeat (2) @(posedge clk_i);
		chk(pin_oe_o, 8'hF7);
		wb(4'h2, 1'b0, 8'h00);
		chk({7'h0, e}, 8'h01);
		finish_test();
	end
endmodule
`default_nettype wire
